// >>> design/crm_requester.sv
// Configuration-message requester: builds token messages for the far
// device's configuration banks and collects its replies.
// Assumes software on APB and a byte token link with valid/ready both ways.
//
// Chosen here: the APB register port.
`default_nettype none
// Functional notes
// - Each request carries the upper 24 bits of the reply channel-end.
// - A return id with low byte all ones means no reply is awaited.
// - Multi-byte fields travel most significant byte first.
// - A status resource id is the register number shifted by 8, OR 0x0C.
// - Tile banks are reached at destination id followed by C20C.
// - Node banks are reached at destination id followed by C30C.
// - Bank write is token 192, return id, 16-bit number, 32 bits, token 1.
// - Bank read is token 193, return id, 16-bit number, token 1.
// - Peripherals are reached at node id, peripheral byte, then 02.
// - Peripheral write is 36, return id, number, size, data, token 1.
// - Peripheral read is 37, return id, number, size, token 1.
module crm_requester
  import crm_pkg::*;
#(
  parameter int BUF_DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [crm_pkg::APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output var logic [31:0] prdata_o,
  output var logic pready_o,
  output var logic pslverr_o,
  output var logic tx_valid_o,
  output var crm_pkg::crm_tok_t tx_tok_o,
  input wire logic tx_ready_i,
  input wire logic rx_valid_i,
  input wire crm_pkg::crm_tok_t rx_tok_i,
  output var logic rx_ready_o,
  output var logic [31:0] chan_dest_o
);
  import crm_pkg::*;

  localparam int AW = $clog2(BUF_DEPTH);
  localparam logic [7:0] DEPTH8 = 8'(BUF_DEPTH);

  crm_state_t s_q;
  crm_state_t s_d;
  logic tx_free;
  logic rx_acc;
  logic is_buf;
  logic unmapped;
  logic [31:0] rval;
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [AW-1:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic per;
  logic [31:0] psid;

  assign per = (s_q.tgt == TGT_PER);
  assign psid = {8'h00, s_q.regnum, 8'h00} | {24'h0, PS_RES_TYPE};

  crm_byte_mem #(
    .DEPTH(BUF_DEPTH),
    .AW(AW)
  ) u_buf (
    .core_clk_i(core_clk_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  // ----------------------------------------------------------------
  // Buffer port steering
  // ----------------------------------------------------------------
  always_comb
  begin
    mem_raddr = paddr_i[AW+1:2];
    if (s_q.st == S_DATA)
    begin
      mem_raddr = s_q.cnt[AW-1:0];
    end
    if (s_q.st == S_RDAT)
    begin
      mem_we = rx_acc && !rx_tok_i.ctrl && per;
      mem_waddr = s_q.cnt[AW-1:0];
      mem_wdata = rx_tok_i.data;
    end
    else
    begin
      mem_we = psel_i && penable_i && s_q.pready && pwrite_i && is_buf;
      mem_waddr = paddr_i[AW+1:2];
      mem_wdata = pwdata_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    is_buf = (paddr_i >= OFF_BUF) && (paddr_i < OFF_BUF + 4 * BUF_DEPTH);
    unmapped = 1'b0;
    rval = 32'h0000_0000;
    case (paddr_i)
      OFF_CTRL: rval = {28'h0, s_q.tgt, s_q.read, 1'b0};
      OFF_DEST: rval = {8'h00, s_q.per_id, s_q.dest_id};
      OFF_RETID: rval = {8'h00, s_q.retid};
      OFF_REGNUM: rval = {16'h0000, s_q.regnum};
      OFF_WDATA: rval = s_q.wdata;
      OFF_SIZE: rval = {24'h0, s_q.size};
      OFF_STATUS: rval = {26'h0, s_q.bad_req, s_q.bad_rep, s_q.fail,
                          s_q.ok, s_q.done, s_q.st != S_IDLE};
      OFF_RDATA: rval = s_q.rdata;
      OFF_PSID: rval = psid;
      default: unmapped = !is_buf;
    endcase
  end

  // ----------------------------------------------------------------
  // Message engine and APB slave
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    tx_free = !s_q.tx_valid || tx_ready_i;
    rx_acc = rx_valid_i && s_q.rx_ready;
    if (s_q.tx_valid && tx_ready_i)
    begin
      s_d.tx_valid = 1'b0;
    end
    case (s_q.st)
      S_IDLE: ;
      S_HDR:
        if (tx_free)
        begin
          s_d.tx_valid = 1'b1;
          s_d.tx_tok.ctrl = 1'b1;
          if (per)
          begin
            s_d.tx_tok.data = s_q.read ? TOK_PER_RD : TOK_PER_WR;
          end
          else
          begin
            s_d.tx_tok.data = s_q.read ? TOK_CFG_RD : TOK_CFG_WR;
          end
          s_d.st = S_RET;
          s_d.cnt = 8'h00;
          s_d.sh = {s_q.retid, 8'h00};
        end
      S_RET, S_REG, S_SIZE:
        if (tx_free)
        begin
          s_d.tx_valid = 1'b1;
          s_d.tx_tok = '{1'b0, s_q.sh[31:24]};
          s_d.sh = {s_q.sh[23:0], 8'h00};
          s_d.cnt = s_q.cnt + 8'h01;
          if (s_q.st == S_RET && s_q.cnt == 8'h02)
          begin
            s_d.st = S_REG;
            s_d.cnt = 8'h00;
            s_d.sh = per ? {s_q.regnum[7:0], 24'h0} : {s_q.regnum, 16'h0};
          end
          else if (s_q.st == S_REG && s_q.cnt == (per ? 8'h00 : 8'h01))
          begin
            s_d.cnt = 8'h00;
            s_d.fetched = 1'b0;
            s_d.sh = per ? {s_q.size, 24'h0} : s_q.wdata;
            s_d.st = per ? S_SIZE : (s_q.read ? S_END : S_DATA);
          end
          else if (s_q.st == S_SIZE)
          begin
            s_d.cnt = 8'h00;
            s_d.st = (s_q.read || s_q.size == 8'h00) ? S_END : S_DATA;
          end
        end
      S_DATA:
        if (!per)
        begin
          if (tx_free)
          begin
            s_d.tx_valid = 1'b1;
            s_d.tx_tok = '{1'b0, s_q.sh[31:24]};
            s_d.sh = {s_q.sh[23:0], 8'h00};
            s_d.cnt = s_q.cnt + 8'h01;
            if (s_q.cnt == 8'h03)
            begin
              s_d.st = S_END;
            end
          end
        end
        else if (!s_q.fetched)
        begin
          // Buffer read is registered, so each byte costs a fetch cycle
          s_d.fetched = 1'b1;
        end
        else if (tx_free)
        begin
          s_d.tx_valid = 1'b1;
          s_d.tx_tok = '{1'b0, mem_rdata};
          s_d.fetched = 1'b0;
          s_d.cnt = s_q.cnt + 8'h01;
          if (s_q.cnt == s_q.size - 8'h01)
          begin
            s_d.st = S_END;
          end
        end
      S_END:
        if (tx_free)
        begin
          s_d.tx_valid = 1'b1;
          s_d.tx_tok = '{1'b1, TOK_END};
          if (s_q.retid[7:0] == RET_NOREPLY)
          begin
            s_d.st = S_IDLE;
            s_d.done = 1'b1;
            s_d.ok = 1'b1;
          end
          else
          begin
            s_d.st = S_RWAIT;
            s_d.rx_ready = 1'b1;
          end
        end
      S_RWAIT:
        if (rx_acc)
        begin
          s_d.cnt = 8'h00;
          s_d.st = S_REND;
          if (rx_tok_i.ctrl && rx_tok_i.data == TOK_ACK)
          begin
            s_d.ok = 1'b1;
            if (s_q.read && !(per && s_q.size == 8'h00))
            begin
              s_d.st = S_RDAT;
            end
          end
          else if (rx_tok_i.ctrl && rx_tok_i.data == TOK_NAK)
          begin
            s_d.fail = 1'b1;
          end
          else
          begin
            s_d.bad_rep = 1'b1;
          end
        end
      S_RDAT:
        if (rx_acc)
        begin
          if (rx_tok_i.ctrl)
          begin
            // Short payload: flag it and resync on the closing token
            s_d.bad_rep = 1'b1;
            s_d.st = S_REND;
            if (rx_tok_i.data == TOK_END)
            begin
              s_d.st = S_IDLE;
              s_d.done = 1'b1;
              s_d.rx_ready = 1'b0;
            end
          end
          else
          begin
            if (!per)
            begin
              s_d.rdata = {s_q.rdata[23:0], rx_tok_i.data};
            end
            s_d.cnt = s_q.cnt + 8'h01;
            if (s_q.cnt == (per ? s_q.size - 8'h01 : 8'h03))
            begin
              s_d.st = S_REND;
            end
          end
        end
      S_REND:
        if (rx_acc)
        begin
          if (rx_tok_i.ctrl && rx_tok_i.data == TOK_END)
          begin
            s_d.st = S_IDLE;
            s_d.done = 1'b1;
            s_d.rx_ready = 1'b0;
          end
          else
          begin
            s_d.bad_rep = 1'b1;
          end
        end
      default: s_d.st = S_IDLE;
    endcase

    // Writes wait for idle so a message never sees its fields move
    if (!(psel_i && penable_i))
    begin
      s_d.pready = 1'b0;
      s_d.armed = 1'b0;
    end
    else if (!s_q.pready)
    begin
      if (pwrite_i)
      begin
        if (s_q.st == S_IDLE)
        begin
          s_d.pready = 1'b1;
          s_d.pslverr = unmapped;
        end
      end
      else if (!is_buf)
      begin
        s_d.pready = 1'b1;
        s_d.pslverr = unmapped;
        s_d.prdata = rval;
      end
      else if (s_q.st == S_IDLE)
      begin
        s_d.armed = 1'b1;
        if (s_q.armed)
        begin
          s_d.pready = 1'b1;
          s_d.pslverr = 1'b0;
          s_d.prdata = {24'h0, mem_rdata};
          s_d.armed = 1'b0;
        end
      end
    end
    else
    begin
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      if (pwrite_i && !s_q.pslverr)
      begin
        case (paddr_i)
          OFF_CTRL:
          begin
            s_d.read = pwdata_i[CTRL_READ];
            s_d.tgt = pwdata_i[CTRL_TGT_LSB+1:CTRL_TGT_LSB];
            if (pwdata_i[CTRL_START])
            begin
              s_d.done = 1'b0;
              s_d.ok = 1'b0;
              s_d.fail = 1'b0;
              s_d.bad_rep = 1'b0;
              s_d.bad_req = 1'b0;
              case (pwdata_i[CTRL_TGT_LSB+1:CTRL_TGT_LSB])
                TGT_TILE: s_d.dest = {s_q.dest_id, DEST_TILE_LO};
                TGT_NODE: s_d.dest = {s_q.dest_id, DEST_NODE_LO};
                TGT_PER: s_d.dest = {s_q.dest_id, s_q.per_id, DEST_PER_LO};
                default: s_d.bad_req = 1'b1;
              endcase
              if (pwdata_i[CTRL_TGT_LSB+1:CTRL_TGT_LSB] == TGT_PER &&
                  s_q.size > DEPTH8)
              begin
                s_d.bad_req = 1'b1;
              end
              if (s_d.bad_req)
              begin
                s_d.done = 1'b1;
              end
              else
              begin
                s_d.st = S_HDR;
              end
            end
          end
          OFF_DEST:
          begin
            s_d.dest_id = pwdata_i[15:0];
            s_d.per_id = pwdata_i[23:16];
          end
          OFF_RETID: s_d.retid = pwdata_i[23:0];
          OFF_REGNUM: s_d.regnum = pwdata_i[15:0];
          OFF_WDATA: s_d.wdata = pwdata_i;
          OFF_SIZE: s_d.size = pwdata_i[7:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      s_q <= CRM_STATE_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign prdata_o = s_q.prdata;
  assign pready_o = s_q.pready;
  assign pslverr_o = s_q.pslverr;
  assign tx_valid_o = s_q.tx_valid;
  assign tx_tok_o = s_q.tx_tok;
  assign rx_ready_o = s_q.rx_ready;
  assign chan_dest_o = s_q.dest;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_CFG_WR_HDR: assert property (
    s_q.st == S_HDR && tx_free && !per && !s_q.read
    |=> tx_valid_o && tx_tok_o == {1'b1, TOK_CFG_WR} && s_q.st == S_RET)
    else $error("bank write header wrong");
  AST_CFG_RD_HDR: assert property (
    s_q.st == S_HDR && tx_free && !per && s_q.read
    |=> tx_tok_o == {1'b1, TOK_CFG_RD} && s_q.st == S_RET)
    else $error("bank read header wrong");
  AST_PER_HDR: assert property (
    s_q.st == S_HDR && tx_free && per
    |=> tx_tok_o.data == (s_q.read ? TOK_PER_RD : TOK_PER_WR))
    else $error("peripheral header wrong");
  AST_RET_MSB: assert property (
    s_q.st == S_RET && s_q.cnt == 8'h00 && tx_free
    |=> !tx_tok_o.ctrl && tx_tok_o.data == $past(s_q.retid[23:16]))
    else $error("return id not high byte first");
  AST_NOREPLY: assert property (
    s_q.st == S_END && tx_free && s_q.retid[7:0] == RET_NOREPLY
    |=> s_q.st == S_IDLE && !rx_ready_o && s_q.done
    ##1 !rx_ready_o)
    else $error("reply awaited despite no-reply id");
  AST_ACK_WR: assert property (
    s_q.st == S_RWAIT && rx_acc && !s_q.read && rx_tok_i == {1'b1, TOK_ACK}
    |=> s_q.st == S_REND && s_q.ok && !s_q.fail)
    else $error("write ack not taken");
  AST_NAK: assert property (
    s_q.st == S_RWAIT && rx_acc && rx_tok_i == {1'b1, TOK_NAK}
    |=> s_q.fail && s_q.st == S_REND)
    else $error("failure reply not flagged");
  AST_RDATA: assert property (
    s_q.st == S_RDAT && rx_acc && !rx_tok_i.ctrl && !per
    |=> s_q.rdata == {$past(s_q.rdata[23:0]), $past(rx_tok_i.data)})
    else $error("read data not shifted in");
  AST_PSID: assert property (
    pready_o && !pwrite_i && paddr_i == OFF_PSID
    |-> prdata_o[7:0] == PS_RES_TYPE && prdata_o[23:8] == s_q.regnum)
    else $error("resource id wrong");
  AST_DEST: assert property (
    s_q.st == S_HDR
    |-> chan_dest_o[15:0] == (s_q.tgt == TGT_TILE ? DEST_TILE_LO :
        s_q.tgt == TGT_NODE ? DEST_NODE_LO : {s_q.per_id, DEST_PER_LO}))
    else $error("destination pattern wrong");
endmodule
`default_nettype wire

// >>> design/crm_pkg.sv
// Package for the configuration-message requester: link tokens, own APB
// register map, message token codes and the far device's status-register map.
// Assumes one clock domain and a byte-wide token link to the far device.
`default_nettype none
package crm_pkg;
  // ----------------------------------------------------------------
  // Token link carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ctrl;
    logic [7:0] data;
  } crm_tok_t;

  // ----------------------------------------------------------------
  // Message token codes
  // ----------------------------------------------------------------
  localparam logic [7:0] TOK_CFG_WR = 8'hC0;
  localparam logic [7:0] TOK_CFG_RD = 8'hC1;
  localparam logic [7:0] TOK_PER_WR = 8'h24;
  localparam logic [7:0] TOK_PER_RD = 8'h25;
  localparam logic [7:0] TOK_END = 8'h01;
  localparam logic [7:0] TOK_ACK = 8'h03;
  localparam logic [7:0] TOK_NAK = 8'h04;
  localparam logic [7:0] RET_NOREPLY = 8'hFF;

  // ----------------------------------------------------------------
  // Channel-end destination patterns
  // ----------------------------------------------------------------
  localparam logic [15:0] DEST_TILE_LO = 16'hC20C;
  localparam logic [15:0] DEST_NODE_LO = 16'hC30C;
  localparam logic [7:0] DEST_PER_LO = 8'h02;
  localparam logic [7:0] PS_RES_TYPE = 8'h0C;
  localparam int PS_RES_SHIFT = 8;

  // ----------------------------------------------------------------
  // Own APB register map
  // ----------------------------------------------------------------
  localparam int APB_AW = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DEST = 8'h04;
  localparam logic [7:0] OFF_RETID = 8'h08;
  localparam logic [7:0] OFF_REGNUM = 8'h0C;
  localparam logic [7:0] OFF_WDATA = 8'h10;
  localparam logic [7:0] OFF_SIZE = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_RDATA = 8'h1C;
  localparam logic [7:0] OFF_PSID = 8'h20;
  localparam logic [7:0] OFF_BUF = 8'h40;
  localparam int CTRL_START = 0;
  localparam int CTRL_READ = 1;
  localparam int CTRL_TGT_LSB = 2;
  localparam logic [1:0] TGT_TILE = 2'h0;
  localparam logic [1:0] TGT_NODE = 2'h1;
  localparam logic [1:0] TGT_PER = 2'h2;

  // ----------------------------------------------------------------
  // Far device status-register numbers and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PS_RAM_BASE_ADDRESS = 8'h00;
  localparam logic [7:0] PS_VECTOR_BASE_ADDRESS = 8'h01;
  localparam logic [7:0] PS_TILE_CONTROL = 8'h02;
  localparam logic [7:0] PS_TILE_BOOT_STATUS = 8'h03;
  localparam logic [7:0] PS_SECURITY_CONFIG = 8'h05;
  localparam logic [7:0] PS_RING_OSC_CONTROL = 8'h06;
  localparam logic [7:0] PS_RING_OSC_COUNT_0 = 8'h07;
  localparam logic [7:0] PS_RING_OSC_COUNT_1 = 8'h08;
  localparam logic [7:0] PS_RING_OSC_COUNT_2 = 8'h09;
  localparam logic [7:0] PS_RING_OSC_COUNT_3 = 8'h0A;
  localparam logic [7:0] PS_MEMORY_SIZE = 8'h0C;
  localparam logic [7:0] PS_DEBUG_SAVED_STATUS = 8'h10;
  localparam logic [7:0] PS_DEBUG_SAVED_PC = 8'h11;
  localparam logic [7:0] PS_DEBUG_SAVED_STACK_PTR = 8'h12;
  localparam logic [7:0] PS_DEBUG_REGREAD_OPERAND_1 = 8'h13;
  localparam logic [7:0] PS_DEBUG_REGREAD_OPERAND_2 = 8'h14;
  localparam logic [7:0] PS_DEBUG_INTERRUPT_TYPE = 8'h15;
  localparam logic [7:0] PS_DEBUG_INTERRUPT_DATA = 8'h16;
  localparam logic [7:0] PS_DEBUG_CORE_CONTROL = 8'h18;
  localparam logic [7:0] PS_DEBUG_SCRATCH_BANK = 8'h20;
  localparam logic [7:0] PS_INSTR_BREAKPOINT_ADDRESS = 8'h30;
  localparam logic [7:0] PS_INSTR_BREAKPOINT_CONTROL = 8'h40;
  localparam logic [7:0] PS_DATA_WATCH_ADDRESS_1 = 8'h50;
  localparam logic [7:0] PS_DATA_WATCH_ADDRESS_2 = 8'h60;
  localparam logic [7:0] PS_DATA_BREAKPOINT_CONTROL = 8'h70;
  localparam logic [7:0] PS_RESOURCE_BREAKPOINT_MASK = 8'h80;
  localparam logic [7:0] PS_RESOURCE_BREAKPOINT_VALUE = 8'h90;
  localparam logic [7:0] PS_RESOURCE_BREAKPOINT_CONTROL = 8'h9C;
  localparam logic [31:0] RAM_BASE_RST = 32'h0004_0000;
  localparam logic [31:0] RAM_BASE_WMASK = 32'hFFFF_FFFC;
  localparam logic [31:0] VEC_BASE_WMASK = 32'hFFFC_0000;

  // ----------------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_HDR, S_RET, S_REG, S_SIZE, S_DATA, S_END,
    S_RWAIT, S_RDAT, S_REND
  } crm_st_t;

  typedef struct packed {
    crm_st_t st;
    logic [7:0] cnt;
    logic [31:0] sh;
    logic fetched;
    logic tx_valid;
    crm_tok_t tx_tok;
    logic rx_ready;
    logic read;
    logic [1:0] tgt;
    logic [15:0] dest_id;
    logic [7:0] per_id;
    logic [23:0] retid;
    logic [15:0] regnum;
    logic [31:0] wdata;
    logic [7:0] size;
    logic [31:0] dest;
    logic [31:0] rdata;
    logic done;
    logic ok;
    logic fail;
    logic bad_rep;
    logic bad_req;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic armed;
  } crm_state_t;

  localparam crm_state_t CRM_STATE_RST = '0;
endpackage
`default_nettype wire

// >>> design/crm_byte_mem.sv
// Byte buffer for peripheral message payloads.
// Assumes one write port and a registered read port on the same clock.
`default_nettype none
module crm_byte_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic core_clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output var logic [7:0] rdata_o
);
  logic [7:0] mem_q [DEPTH];

  // ----------------------------------------------------------------
  // Storage, no reset: contents are payload only
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule
`default_nettype wire

// >>> tb/crm_dev_model.sv
// Far device model: status-register bank behind the byte token link.
// Assumes one clock; the bench drives stall_i to slow token acceptance.
`default_nettype none
module crm_dev_model
  import crm_pkg::*;
(
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic tx_valid_i,
  input wire crm_pkg::crm_tok_t tx_tok_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  output crm_pkg::crm_tok_t rx_tok_o,
  input wire logic rx_ready_i
);
  logic [31:0] ps [256];
  logic [31:0] wm;
  logic [15:0] rn;
  logic ok;
  crm_tok_t m[$];
  crm_tok_t r[$];
  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  function automatic logic impl(logic [15:0] n);
    return n < 16'h100 && n[7:0] inside {[8'h00:8'h03], [8'h05:8'h0A],
      8'h0C, [8'h10:8'h16], 8'h18, [8'h20:8'h27], [8'h30:8'h33],
      [8'h40:8'h43], [8'h50:8'h53], [8'h60:8'h63], [8'h70:8'h73],
      [8'h80:8'h83], [8'h90:8'h93], [8'h9C:8'h9F]};
  endfunction
  initial
  begin
    foreach (ps[i]) ps[i] = '0;
    ps[0] = RAM_BASE_RST;
    tx_ready_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_tok_o = '0;
  end
  task automatic serve();
    rn = {m[4].data, m[5].data};
    wm = rn == 0 ? RAM_BASE_WMASK : rn == 1 ? VEC_BASE_WMASK : '1;
    ok = 1'b1;
    if (m[0].data == TOK_CFG_WR)
      ok = m.size() == 11 && impl(rn) && !(rn inside {3, [7:10], 12});
    if (m[0].data == TOK_CFG_RD)
      ok = m.size() == 7 && impl(rn);
    if (ok && m[0].data == TOK_CFG_WR)
      ps[rn[7:0]] = {m[6].data, m[7].data, m[8].data, m[9].data} & wm
        | ps[rn[7:0]] & ~wm;
    if (m[3].data != RET_NOREPLY)
    begin
      r.push_back({1'b1, ok ? TOK_ACK : TOK_NAK});
      for (int i = 3; i >= 0 && ok && m[0].data == TOK_CFG_RD; i--)
        r.push_back({1'b0, ps[rn[7:0]][8*i+:8]});
      for (int i = 0; i < m[5].data && m[0].data == TOK_PER_RD; i++)
        r.push_back({1'b0, m[4].data + 8'(i)});
      r.push_back({1'b1, TOK_END});
    end
  endtask
  // Released data line inverts every cycle, so the stale token returns every other cycle
  always @(posedge clk_i)
  begin
    if (rx_valid_o && rx_ready_i)
      void'(r.pop_front());
    if (tx_valid_i && tx_ready_o)
      m.push_back(tx_tok_i);
    if (tx_valid_i && tx_ready_o && tx_tok_i == {1'b1, TOK_END})
    begin
      serve();
      m = {};
    end
    tx_ready_o <= !stall_i;
    rx_valid_o <= r.size() > 0;
    rx_tok_o <= r.size() > 0 ? r[0] : ~rx_tok_o;
  end
endmodule
`default_nettype wire

// >>> tb/tb_crm_requester.sv
// Bench for the requester: APB software side, device model on the link.
// Assumes crm_pkg, the design and the device model compile first.
`default_nettype none
module tb_crm_requester;
  timeunit 1ns;
  timeprecision 100ps;
  import crm_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, perr, er;
  logic txv, txr, rxv, rxr, stall, slow;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, cdest, q, r, sh [256];
  crm_tok_t ttok, rtok, seen[$], ex[$];
  logic [15:0] rtab [8] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h5, 16'hC,
    16'h4, 16'h100};
  logic [7:0] rdok = 8'h3F, wrok = 8'h17;
  int failures, num_checks, seed;
  crm_requester uut (.core_clk_i(clk), .sys_rst_i(rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .tx_valid_o(txv), .tx_tok_o(ttok), .tx_ready_i(txr),
    .rx_valid_i(rxv), .rx_tok_i(rtok), .rx_ready_o(rxr),
    .chan_dest_o(cdest));
  crm_dev_model dev (.clk_i(clk), .stall_i(stall), .tx_valid_i(txv),
    .tx_tok_i(ttok), .tx_ready_o(txr), .rx_valid_o(rxv), .rx_tok_o(rtok),
    .rx_ready_i(rxr));
  // ----------------------------------------------------------------
  // Clock, stalls, link snoop, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
    stall <= slow & 1'($random(seed));
  always @(posedge clk)
    if (txv && txr)
      seen.push_back(ttok);
  initial
  begin
    repeat (60000) @(posedge clk);
    failures++;
    conclude();
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 200);
    q = prdata;
    er = perr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 200)
      chk("pready", 0, 1);
    @(posedge clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic pb(logic [31:0] v, int nb);
    for (int i = nb - 1; i >= 0; i--)
      ex.push_back({1'b0, v[8*i+:8]});
  endtask
  task automatic op(logic [1:0] t, logic rdn, logic [23:0] ret,
    logic [2:0] k, logic [31:0] wd, logic [7:0] sz);
    logic [15:0] rn;
    logic [31:0] d, m;
    logic bad, ok, nr;
    rn = t == 2 ? {8'h00, wd[15:8]} : rtab[k];
    d = {8'h00, wd[31:8]};
    nr = ret[7:0] == 8'hFF;
    bad = t == 3 || (t == 2 && sz > 8);
    ok = nr || t == 2 || (rdn ? rdok[k] : wrok[k]);
    seen = {};
    ex = {};
    for (int i = 0; i < 8; i++)
      wr(OFF_BUF + 8'(4 * i), 32'(wd[7:0] ^ 8'(i * 37)));
    wr(OFF_DEST, d);
    wr(OFF_RETID, {8'h00, ret});
    wr(OFF_REGNUM, {16'h0, rn});
    wr(OFF_WDATA, wd);
    wr(OFF_SIZE, {24'h0, sz});
    wr(OFF_CTRL, {28'h0, t, rdn, 1'b1});
    q = '0;
    for (int n = 0; n < 300 && q[1] !== 1'b1; n++)
      rd(OFF_STATUS);
    // No-reply done comes before token 01 is taken
    while (txv === 1'b1) @(posedge clk);
    chk("status", q, {26'h0, bad, 1'b0, !bad && !ok, !bad && ok, 2'b10});
    m = t == 0 ? {d[15:0], 16'hC20C} : t == 1 ? {d[15:0], 16'hC30C}
      : {d[15:0], d[23:16], 8'h02};
    if (!bad)
      chk("dest", cdest, m);
    if (!bad)
    begin
      ex.push_back({1'b1, (t == 2 ? 8'h24 : 8'hC0) | {7'h0, rdn}});
      pb({8'h0, ret}, 3);
      pb(t == 2 ? {16'h0, rn[7:0], sz} : {16'h0, rn}, 2);
      if (!rdn && t < 2)
        pb(wd, 4);
      for (int i = 0; i < sz && !rdn && t == 2; i++)
        pb(32'(wd[7:0] ^ 8'(i * 37)), 1);
      ex.push_back({1'b1, 8'h01});
    end
    chk("count", 32'(seen.size()), 32'(ex.size()));
    foreach (ex[i]) chk("token", 32'(seen[i]), 32'(ex[i]));
    m = rn == 0 ? 32'hFFFF_FFFC : rn == 1 ? 32'hFFFC_0000 : '1;
    if (!rdn && t < 2 && wrok[k])
      sh[rn[7:0]] = wd & m | sh[rn[7:0]] & ~m;
    rd(OFF_PSID);
    chk("psid", q, {8'h0, rn, 8'h0C});
    if (rdn && t < 2 && rdok[k] && !nr)
    begin
      rd(OFF_RDATA);
      chk("rdata", q, sh[rn[7:0]]);
    end
    for (int i = 0; i < sz && rdn && t == 2 && !bad && !nr; i++)
    begin
      rd(OFF_BUF + 8'(4 * i));
      chk("buf", {24'h0, q[7:0]}, 32'(rn[7:0] + 8'(i)));
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst, psel, penable, pwrite, slow} = 5'b10000;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'h6173FE2B;
    foreach (sh[i]) sh[i] = '0;
    sh[0] = 32'h0004_0000;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    op(0, 1, 24'h123400, 0, 0, 0);
    op(1, 0, 24'h1234FF, 1, '1, 0);
    op(0, 1, 24'h123456, 1, 0, 0);
    op(1, 0, 24'h123401, 0, '1, 0);
    op(0, 1, 24'h123402, 0, 0, 0);
    op(2, 0, 24'h000100, 0, 32'hA5, 9);
    op(2, 0, 24'h000100, 0, 32'h5A, 8);
    op(3, 1, 24'h000100, 0, 0, 1);
    $display("test directed done");
    rd(OFF_STATUS);
    r = q;
    wr(OFF_STATUS, '1);
    rd(8'h30);
    chk("pslverr", {31'h0, er}, 1);
    rd(OFF_STATUS);
    chk("status_ro", q, r);
    $display("test apb_map done");
    slow = 1'b1;
    repeat (40)
    begin
      r = $random(seed);
      op(2'(r), r[2], {r[31:16], r[3] & r[4] ? 8'hFF : r[15:8]},
        3'(r >> 5), $random(seed), 8'(r[10:8]) + 8'(r[11]));
    end
    $display("test random done");
    conclude();
  end
endmodule
`default_nettype wire
